// ---- hdl/io_read_watchdog_timer.sv ----
/*
 * watchdog driven only by host i/o reads: one port arms and refreshes,
 * another stops it. straps pick the period and the expiry action.
 * assumes the i/o read strobe is one clock wide and synchronous, and
 * that the straps stay still while the system runs.
 */
`timescale 1ns/1ps
`include "wdt_defs.svh"
module io_read_watchdog_timer
#(
	parameter int TICK_CYC = `WDT_TICK_CYC,   // clocks per ms tick
	parameter int MS_PER_S = `WDT_MS_PER_S,   // ticks per second
	parameter int RST_CYC  = `WDT_RST_CYC     // reset pulse width
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_b_in,
	input  wire logic [`WDT_ADDR_W-1:0]  io_addr_in,
	input  wire logic                    io_rd_in,
	input  wire logic                    io_wr_in,
	input  wire wdt_pkg::expiry_action_t expiry_action_select_in,
	input  wire logic [3:0]              timeout_period_select_in,
	output logic [`WDT_DATA_W-1:0]       io_rdata_out,
	output logic                         io_rdata_oe_out,
	output logic                         sys_reset_out,
	output logic                         nmi_out,
	output logic                         armed_out
);
	import wdt_pkg::*;

	// ------------------------------------------------------------
	// port decode
	// ------------------------------------------------------------
	// full 16-bit compare so bit ten separates the two ports
	wire hit_arm  = (io_addr_in == `WDT_ARM_PORT);
	wire hit_stop = (io_addr_in == `WDT_STOP_PORT);
	// writes never reach the decode; the write strobe only feeds a
	// check below, so a host that writes instead of reads sees nothing
	wire rd_arm   = io_rd_in && hit_arm;
	wire rd_stop  = io_rd_in && hit_stop;

	// ------------------------------------------------------------
	// period select: strap pattern to whole seconds
	// ------------------------------------------------------------
	logic [7:0] period_s;   // chosen period in seconds
	always_comb begin
		case (timeout_period_select_in)
			4'h2:    period_s = 8'(`WDT_P0_S);
			4'h3:    period_s = 8'(`WDT_P1_S);
			4'h4:    period_s = 8'(`WDT_P2_S);
			4'h5:    period_s = 8'(`WDT_P3_S);
			4'h8:    period_s = 8'(`WDT_P4_S);
			4'h9:    period_s = 8'(`WDT_P5_S);
			// unlisted patterns fall back to the 1 s default
			default: period_s = 8'(`WDT_P0_S);
		endcase
	end

	// ------------------------------------------------------------
	// millisecond tick from the shared divider
	// ------------------------------------------------------------
	tick_if tk ();
	tick_divider #(
		.DIV_CYC (TICK_CYC)
	) u_div (
		.sys_clk_in (sys_clk_in),
		.rst_b_in   (rst_b_in),
		.tk         (tk.src)
	);

	// ------------------------------------------------------------
	// counters: ms within a second, seconds elapsed
	// ------------------------------------------------------------
	wdt_state_t  state_r, state_nxt;
	logic [9:0]  ms_r;     // ms into the current second
	logic [7:0]  sec_r;    // whole seconds since arm/refresh
	logic [4:0]  pulse_r;  // remaining reset pulse cycles

	wire sec_wrap = tk.tick && (ms_r == 10'(MS_PER_S - 1));
	// expiry once the last second of the period completes
	wire expire   = (state_r == ST_ARMED) && sec_wrap
	                && (sec_r == period_s - 8'h01);
	wire act_off  = (expiry_action_select_in == ACT_OFF) ||
	                (expiry_action_select_in == ACT_RSVD);

	// ------------------------------------------------------------
	// arm state machine; stop wins over arm in the same cycle
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  if (rd_arm && !rd_stop) state_nxt = ST_ARMED;
			ST_ARMED: begin
				if (rd_stop)      state_nxt = ST_IDLE;
				else if (rd_arm)  state_nxt = ST_ARMED;  // refresh
				else if (expire)  state_nxt = ST_FIRED;
			end
			// after firing the timer waits for a stop or a re-arm
			ST_FIRED: begin
				if (rd_stop)     state_nxt = ST_IDLE;
				else if (rd_arm) state_nxt = ST_ARMED;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// state register; reset leaves it disarmed
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// counting runs only while armed; any arm read zeroes it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || rd_arm || rd_stop || state_r != ST_ARMED) begin
			ms_r  <= 10'h000;
			sec_r <= 8'h00;
		end else if (sec_wrap) begin
			ms_r  <= 10'h000;
			sec_r <= sec_r + 8'h01;
		end else if (tk.tick) begin
			ms_r  <= ms_r + 10'h001;
		end
	end

	// ------------------------------------------------------------
	// expiry outputs, gated by the action strap
	// ------------------------------------------------------------
	wire fire_now = expire && !rd_arm && !rd_stop;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			pulse_r       <= 5'h00;
			sys_reset_out <= 1'b0;
			nmi_out       <= 1'b0;
		end else begin
			// reset is stretched so the system sees it reliably
			if (fire_now && expiry_action_select_in == ACT_RESET)
				pulse_r <= 5'(RST_CYC);
			else if (pulse_r != 5'h00)
				pulse_r <= pulse_r - 5'h01;
			sys_reset_out <= (fire_now &&
				expiry_action_select_in == ACT_RESET) ||
				(pulse_r > 5'h01);
			// nmi is a single edge-style pulse
			nmi_out <= fire_now && (expiry_action_select_in == ACT_NMI)
			           && !act_off;
		end
	end

	// ------------------------------------------------------------
	// read data and status; the data value carries no meaning
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			io_rdata_out    <= `WDT_DATA_W'(0);
			io_rdata_oe_out <= 1'b0;
			armed_out       <= 1'b0;
		end else begin
			io_rdata_out    <= `WDT_READ_DATA;
			io_rdata_oe_out <= rd_arm || rd_stop;
			armed_out       <= (state_nxt == ST_ARMED);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_stop_read;
		io_rd_in && hit_stop;
	endsequence
	sequence s_quiet_after;
		!sys_reset_out && !nmi_out;
	endsequence

	a_stop_disarms : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in) s_stop_read |=> state_r == ST_IDLE)
		else $error("stop read left timer armed");
	a_arm_from_idle : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(state_r == ST_IDLE && rd_arm && !rd_stop) |=> armed_out)
		else $error("arm read did not arm");
	a_refresh_zero : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(state_r == ST_ARMED && rd_arm && !rd_stop)
		|=> (sec_r == 8'h00 && ms_r == 10'h000))
		else $error("refresh did not clear count");
	a_refresh_stays : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(state_r == ST_ARMED && rd_arm && !rd_stop)
		|=> state_r == ST_ARMED)
		else $error("refresh changed state");
	a_write_noeff : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(!io_rd_in && state_r == ST_IDLE) |=> state_r == ST_IDLE)
		else $error("non-read access armed timer");
	a_idle_quiet : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(state_r == ST_IDLE && pulse_r <= 5'h01) |=> s_quiet_after)
		else $error("expiry output while disarmed");
	a_off_silent : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(act_off && pulse_r <= 5'h01) |=> s_quiet_after)
		else $error("output fired with watchdog off");
	a_nmi_on_exp : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(fire_now && expiry_action_select_in == ACT_NMI)
		|=> nmi_out ##1 !nmi_out)
		else $error("nmi not one pulse at expiry");
	a_rst_on_exp : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(fire_now && expiry_action_select_in == ACT_RESET)
		|=> sys_reset_out[*8])
		else $error("reset pulse too short");
	// the arm address with only bit ten flipped must never arm
	a_decode_bit10 : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(io_rd_in && io_addr_in == (`WDT_ARM_PORT ^ `WDT_SEL_MASK))
		|=> !armed_out)
		else $error("bit ten ignored in port decode");
	// a write cycle alone must leave an unarmed timer unarmed
	a_write_ignored : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in)
		(io_wr_in && !io_rd_in && state_r != ST_ARMED) |=> !armed_out)
		else $error("write cycle armed timer");
endmodule : io_read_watchdog_timer

// ---- hdl/tick_divider.sv ----
/*
 * divider producing a one-cycle enable every DIV_CYC clocks.
 * assumes a synchronous, active-low reset.
 */
`timescale 1ns/1ps
`include "wdt_defs.svh"
module tick_divider #(
	parameter int DIV_CYC = `WDT_TICK_CYC
) (
	input  wire logic sys_clk_in,
	input  wire logic rst_b_in,
	tick_if.src       tk
);
	// ------------------------------------------------------------
	// free-running cycle counter
	// ------------------------------------------------------------
	logic [17:0] cnt_r;   // cycles into current tick
	logic        wrap;    // last cycle of the tick

	assign wrap = (cnt_r == 18'(DIV_CYC - 1));

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			cnt_r   <= 18'h0_0000;
			tk.tick <= 1'b0;
		end else begin
			cnt_r   <= wrap ? 18'h0_0000 : cnt_r + 18'h0_0001;
			tk.tick <= wrap;
		end
	end

	// tick is one cycle wide and never back to back
	a_tick_single : assert property (@(posedge sys_clk_in)
		disable iff (!rst_b_in) tk.tick |=> !tk.tick)
		else $error("tick held longer than one cycle");
endmodule : tick_divider

// ---- inc/tick_if.sv ----
/*
 * carries the millisecond tick between the divider and the watchdog.
 * assumes a single clock domain.
 */
`timescale 1ns/1ps
interface tick_if;
	logic tick;   // one-cycle pulse every millisecond
	modport src  (output tick);
	modport sink (input tick);
endinterface : tick_if

// ---- inc/wdt_defs.svh ----
/*
 * constants for the i/o read watchdog: port addresses, bus widths,
 * timeout periods in seconds and tick timing.
 * assumes the includer builds with a 250 mhz system clock.
 */
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------
// i/o bus shape and port addresses
// ----------------------------------------------------------------
`define WDT_ADDR_W      16
`define WDT_DATA_W      8
`define WDT_ARM_PORT    16'h0443
`define WDT_STOP_PORT   16'h0043
// the one address bit that tells the two ports apart
`define WDT_SEL_MASK    16'h0400
`define WDT_READ_DATA   8'hFF

// ----------------------------------------------------------------
// timebase: one tick per millisecond from the 250 mhz clock
// ----------------------------------------------------------------
`define WDT_CLK_MHZ     250
`define WDT_TICK_US     1000
`define WDT_TICK_CYC    (`WDT_CLK_MHZ * `WDT_TICK_US)
// reset pulse stretch in clocks, long enough for the system to see it
`define WDT_RST_CYC     16

// ----------------------------------------------------------------
// timeout periods in seconds, and ms ticks per second
// ----------------------------------------------------------------
`define WDT_MS_PER_S    1000
`define WDT_P0_S        1
`define WDT_P1_S        2
`define WDT_P2_S        10
`define WDT_P3_S        20
`define WDT_P4_S        110
`define WDT_P5_S        220

`endif

// ---- inc/wdt_pkg.sv ----
/*
 * types shared by the watchdog modules.
 * assumes wdt_defs.svh supplies the numeric constants.
 */
package wdt_pkg;
	// expiry action strap code
	typedef enum logic [1:0] {
		ACT_RESET   = 2'b00,
		ACT_NMI     = 2'b01,
		ACT_OFF     = 2'b10,
		ACT_RSVD    = 2'b11
	} expiry_action_t;

	// arm state, gray along idle -> armed -> fired
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_FIRED = 2'b11
	} wdt_state_t;
endpackage : wdt_pkg

// ---- verif/host_io_model.sv ----
/*
 * host side model: issues single i/o read or write cycles on command.
 * assumes a free running clock and a bench that calls cycle().
 */
`timescale 1ns/1ps
`include "wdt_defs.svh"
module host_io_model (
	input  wire logic                  sys_clk_in,
	output logic [`WDT_ADDR_W-1:0]     io_addr_out,
	output logic                       io_rd_out,
	output logic                       io_wr_out
);
	// ------------------------------------------------------------
	// bus idles with no strobe
	// ------------------------------------------------------------
	initial begin
		io_addr_out = 16'h0000;
		io_rd_out   = 1'b0;
		io_wr_out   = 1'b0;
	end

	// one strobe clock; afterwards the address floats, shown inverted
	// so that a stale address can never pass for a fresh decode
	task automatic cycle(input logic [`WDT_ADDR_W-1:0] addr,
			input logic wr);
		@(negedge sys_clk_in);
		io_addr_out = addr;
		io_rd_out   = ~wr;
		io_wr_out   = wr;    // writes only when a refusal is wanted
		@(negedge sys_clk_in);
		io_rd_out   = 1'b0;
		io_wr_out   = 1'b0;
		io_addr_out = ~addr;
	endtask : cycle
endmodule : host_io_model

// ---- verif/io_read_watchdog_timer_tb_top.sv ----
/*
 * self-checking bench for the i/o read watchdog, short tick counts.
 * assumes host_io_model drives the bus and straps change in reset.
 */
`timescale 1ns/1ps
`include "wdt_defs.svh"
module io_read_watchdog_timer_tb_top;
	import wdt_pkg::*;
	// ------------------------------------------------------------
	// shortened timebase: one second is CYC_S clocks
	// ------------------------------------------------------------
	localparam int TK = 4, MS = 3, RSTW = 16, CYC_S = TK * MS;
	localparam logic [15:0] ARM = `WDT_ARM_PORT, STOP = `WDT_STOP_PORT;
	typedef struct { logic [3:0] sel; int secs; } row_t;
	row_t rows [7] = '{'{4'h2, 1}, '{4'h3, 2}, '{4'h4, 10},
		'{4'h5, 20}, '{4'h8, 110}, '{4'h9, 220}, '{4'h0, 1}};
	logic           clk = 1'b0, rst_b = 1'b0, rd, wr, oe, srst, nmi, armed;
	logic [15:0]    addr;
	logic [7:0]     rdata;
	expiry_action_t act = ACT_RESET;
	logic [3:0]     per = 4'h2;
	int             err_total = 0, n_tests = 0;
	logic [15:0]    bad [3] = '{16'h0643, 16'h0447, 16'h1443};

	always #2 clk = ~clk;   // 250 mhz

	host_io_model host_u (.sys_clk_in(clk), .io_addr_out(addr),
		.io_rd_out(rd), .io_wr_out(wr));
	io_read_watchdog_timer #(.TICK_CYC(TK), .MS_PER_S(MS),
		.RST_CYC(RSTW)) dut_u (.sys_clk_in(clk), .rst_b_in(rst_b),
		.io_addr_in(addr), .io_rd_in(rd), .io_wr_in(wr),
		.expiry_action_select_in(act), .timeout_period_select_in(per),
		.io_rdata_out(rdata), .io_rdata_oe_out(oe), .sys_reset_out(srst),
		.nmi_out(nmi), .armed_out(armed));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_range(input string nm, input int v, lo, hi);
		n_tests++;
		if (v < lo || v > hi) begin
			err_total++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, v);
		end
	endtask : chk_range
	task automatic test_done();
		$display("mismatches %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// stimulus helpers
	// ------------------------------------------------------------
	// straps only move while reset is held
	task automatic do_reset(input expiry_action_t a, input logic [3:0] p);
		@(negedge clk);
		rst_b = 1'b0;
		act   = a;
		per   = p;
		repeat (20) @(negedge clk);
		chk_bit("armed_in_reset", 1'b0, armed);
		rst_b = 1'b1;
	endtask : do_reset
	// read, then look at the one-cycle answer
	task automatic rd_port(input logic [15:0] a, input logic hit);
		host_u.cycle(a, 1'b0);
		chk_bit("rdata_oe", hit, oe);
		if (hit) chk_bit("rdata_const", 1'b1, rdata === `WDT_READ_DATA);
	endtask : rd_port
	task automatic quiet(input int cyc);
		int hits;
		hits = 0;
		repeat (cyc) begin
			@(negedge clk);
			if (srst !== 1'b0 || nmi !== 1'b0) hits++;
		end
		chk_range("no_expiry", hits, 0, 0);
	endtask : quiet
	// delay from the last arm or refresh, then the pulse width
	task automatic wait_fire(input int secs, input logic use_nmi);
		int n;
		n = 0;
		while (srst !== 1'b1 && nmi !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk_range("fire_delay", n, CYC_S*secs-TK+1, CYC_S*secs);
		if (n >= 3000) test_done();
		chk_bit("other_out", 1'b0, use_nmi ? srst : nmi);
		n = 0;
		while ((use_nmi ? nmi : srst) === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk_range("pulse_width", n, use_nmi ? 1 : RSTW,
			use_nmi ? 1 : RSTW);
	endtask : wait_fire

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset(ACT_RESET, 4'h2);
		quiet(60);
		foreach (rows[i]) begin   // every listed period code plus unlisted 0, default action
			do_reset(ACT_RESET, rows[i].sel);
			rd_port(ARM, 1'b1);
			chk_bit("armed_set", 1'b1, armed);
			wait_fire(rows[i].secs, 1'b0);
		end
		do_reset(ACT_NMI, 4'h2);
		rd_port(ARM, 1'b1);
		wait_fire(1, 1'b1);
		quiet(40);
		do_reset(ACT_RESET, 4'h2);
		rd_port(ARM, 1'b1);
		repeat (8) @(negedge clk);
		rd_port(ARM, 1'b1);
		chk_bit("armed_refresh", 1'b1, armed);
		wait_fire(1, 1'b0);
		rd_port(ARM, 1'b1);
		rd_port(STOP, 1'b1);   // arm then stop, one idle clock apart
		chk_bit("armed_stop", 1'b0, armed);
		quiet(40);
		host_u.cycle(ARM, 1'b1);
		chk_bit("write_oe", 1'b0, oe);
		foreach (bad[i]) rd_port(bad[i], 1'b0);
		chk_bit("armed_refused", 1'b0, armed);
		quiet(40);
		do_reset(ACT_OFF, 4'h2);
		rd_port(ARM, 1'b1);
		quiet(60);
		do_reset(ACT_RSVD, 4'h2);
		rd_port(ARM, 1'b1);
		quiet(60);
		// a reset in mid-count must drop the arming for good
		do_reset(ACT_RESET, 4'h2);
		rd_port(ARM, 1'b1);
		do_reset(ACT_RESET, 4'h2);
		quiet(60);
		test_done();
	end
endmodule : io_read_watchdog_timer_tb_top
